// ==== verilog/interlock_map.svh ====
`ifndef INTERLOCK_MAP_SVH
`define INTERLOCK_MAP_SVH

// register byte offsets
`define IL_CTRL_OFFSET        8'h00
`define IL_STATE_OFFSET       8'h04
`define IL_IRQ_STATUS_OFFSET  8'h08
`define IL_IRQ_MASK_OFFSET    8'h0c
`define IL_FUNC_BASE_OFFSET   8'h40

// control register fields
`define IL_CTRL_ESTOP_REC_LSB   0
`define IL_CTRL_DEADMAN_REC_LSB 4
`define IL_CTRL_SW_DRIVE_BIT    8
`define IL_CTRL_SW_PAUSE_BIT    9
`define IL_CTRL_RESET           32'h0000_0000

// state register fields
`define IL_ST_POWER_BIT    0
`define IL_ST_CUTOFF_BIT   1
`define IL_ST_P_ESTOP_BIT  2
`define IL_ST_P_DEAD_BIT   3
`define IL_ST_P_INPUT_BIT  4
`define IL_ST_PAUSED_BIT   5
`define IL_ST_CAUSE_BIT    8
`define IL_ST_ESTOP_BIT    9
`define IL_ST_DEADMAN_BIT  10

// interrupt events
`define IL_EV_CUTOFF       0
`define IL_EV_RESTORED     1
`define IL_EV_PAUSED       2
`define IL_EV_RESUMED      3
`define IL_EV_WIDTH        4
`define IL_IRQ_MASK_RESET  4'h0

// input function codes and recovery setting
`define IL_FC_DRIVE_RESET  8'h11
`define IL_FC_PAUSE_INPUT  8'h08
`define IL_FC_PAUSE_RESET  8'h07
`define IL_FC_RESET        8'h00
`define IL_REC_CONTINUE    4'h2
`define IL_REC_RESET       4'h0

// general inputs: 16 ports numbered 30..45, then 8 numbered 251..258
`define IL_NUM_PORTS       24

// axi responses
`define IL_RESP_OKAY       2'h0
`define IL_RESP_DECERR     2'h3

`endif

// ==== verilog/interlock_pkg.sv ====
package interlock_pkg;
   typedef logic [7:0] func_code_t;
   typedef logic [3:0] rec_mode_t;
   typedef logic [1:0] axi_resp_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_RESP = 2'b01
   } rd_state_t;
endpackage

// ==== verilog/input_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
   parameter int W = 27
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         logic lv;
         logic rs;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end else begin
               s1 <= raw[i];
               s2 <= s1;
               s3 <= s2;
            end
         end
         // level moves only once second and third stage agree
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               lv <= 1'b0;
               rs <= 1'b0;
            end else begin
               if (s2 == s3) begin
                  lv <= s3;
               end
               rs <= (s2 == s3) && s3 && !lv;
            end
         end
         assign level[i] = lv;
         assign rise[i]  = rs;
         a_single_rise : assert property (@(posedge aclk) disable iff (!aresetn)
            rs |=> !rs)
         else $error("input event repeated without a new transition");
      end
   endgenerate
endmodule // input_sync
`default_nettype wire

// ==== verilog/pause_interlock.sv ====
// How it works
// - a general input becomes the drive-source cutoff reset when its function code is 17, and only ports 30..45 and 251..258 exist to carry it.
// - a rising edge on a cutoff-reset port is a drive-source recovery request.
// - after a cutoff, drive power stays off until the cause is gone and a recovery request then arrives.
// - with emergency-stop recovery set to 2, an emergency stop in auto leaves a pause that only a pause reset after release clears.
// - with deadman/enable recovery set to 2, such a stop in auto leaves a pause that only a pause reset after the stop clears.
// - a port with code 8 is a pause input: low in auto pauses, high afterwards clears the pause.
// - a rising edge on a port with code 7 is an operation-pause reset request.
`include "interlock_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pause_interlock #(
   parameter int ADDR_W = 8,
   parameter int NPORT  = `IL_NUM_PORTS
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [NPORT-1:0]  port_in,
   input  wire logic              estop_in,
   input  wire logic              deadman_stop_in,
   input  wire logic              cutoff_cause_in,
   input  wire logic              auto_mode,
   output logic                   drive_power_en,
   output logic                   paused,
   output logic                   irq
);
   localparam int SW = NPORT + 3;

   logic [SW-1:0]              sync_level;
   logic [SW-1:0]              sync_rise;
   logic [NPORT-1:0]           port_level;
   logic [NPORT-1:0]           port_rise;
   logic                       estop_lvl;
   logic                       dead_lvl;
   logic                       cause_lvl;
   interlock_pkg::func_code_t  func_code [NPORT];
   logic [NPORT-1:0]           is_drive_rst;
   logic [NPORT-1:0]           is_pause_in;
   logic [NPORT-1:0]           is_pause_rst;
   interlock_pkg::rec_mode_t   estop_rec;
   interlock_pkg::rec_mode_t   dead_rec;
   logic                       sw_drive_req;
   logic                       sw_pause_req;
   logic                       drive_req;
   logic                       pause_req;
   logic                       pause_low;
   logic                       cutoff_latched;
   logic                       pause_estop;
   logic                       pause_dead;
   logic                       pause_input;
   logic                       next_cutoff;
   logic                       next_pause_estop;
   logic                       next_pause_dead;
   logic                       next_pause_input;
   logic [`IL_EV_WIDTH-1:0]    events;
   logic [`IL_EV_WIDTH-1:0]    irq_status;
   logic [`IL_EV_WIDTH-1:0]    irq_mask;
   logic [`IL_EV_WIDTH-1:0]    next_irq_status;
   logic [ADDR_W-1:0]          w_addr;
   logic [31:0]                w_data;
   logic [3:0]                 w_strb;
   logic                       wr_fire;
   logic                       rd_fire;
   logic                       rd_clear;
   logic                       wr_mapped;
   logic [31:0]                rd_word;
   logic                       rd_mapped;
   logic [31:0]                state_word;
   interlock_pkg::rd_state_t   rd_state;

   input_sync #(
      .W (SW)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .raw     ({cutoff_cause_in, deadman_stop_in, estop_in, port_in}),
      .level   (sync_level),
      .rise    (sync_rise)
   );

   assign port_level = sync_level[NPORT-1:0];
   assign port_rise  = sync_rise[NPORT-1:0];
   assign estop_lvl  = sync_level[NPORT];
   assign dead_lvl   = sync_level[NPORT+1];
   assign cause_lvl  = sync_level[NPORT+2];

   // ---------------- bus write side ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         w_addr        <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         w_addr        <= s_axi_awaddr;
      end else if (wr_fire) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_data       <= '0;
         w_strb       <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
      end else if (wr_fire) begin
         s_axi_wready <= 1'b1;
      end
   end

   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_comb begin
      wr_mapped = (w_addr == `IL_CTRL_OFFSET) || (w_addr == `IL_IRQ_MASK_OFFSET) ||
                  (w_addr == `IL_STATE_OFFSET) || (w_addr == `IL_IRQ_STATUS_OFFSET);
      for (int k = 0; k < NPORT; k++) begin
         if (w_addr == ADDR_W'(`IL_FUNC_BASE_OFFSET + 4 * k)) begin
            wr_mapped = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `IL_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? `IL_RESP_OKAY : `IL_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control: recovery settings and one-cycle software requests
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         estop_rec    <= `IL_REC_RESET;
         dead_rec     <= `IL_REC_RESET;
         sw_drive_req <= 1'b0;
         sw_pause_req <= 1'b0;
         irq_mask     <= `IL_IRQ_MASK_RESET;
      end else begin
         sw_drive_req <= 1'b0;
         sw_pause_req <= 1'b0;
         if (wr_fire && w_addr == `IL_CTRL_OFFSET) begin
            if (w_strb[0]) begin
               estop_rec <= w_data[`IL_CTRL_ESTOP_REC_LSB +: 4];
               dead_rec  <= w_data[`IL_CTRL_DEADMAN_REC_LSB +: 4];
            end
            if (w_strb[1]) begin
               sw_drive_req <= w_data[`IL_CTRL_SW_DRIVE_BIT];
               sw_pause_req <= w_data[`IL_CTRL_SW_PAUSE_BIT];
            end
         end
         if (wr_fire && w_addr == `IL_IRQ_MASK_OFFSET && w_strb[0]) begin
            irq_mask <= w_data[`IL_EV_WIDTH-1:0];
         end
      end
   end

   // function code table, one entry per general input
   genvar i;
   generate
      for (i = 0; i < NPORT; i = i + 1) begin : g_port
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               func_code[i] <= `IL_FC_RESET;
            end else if (wr_fire && w_strb[0] &&
                         w_addr == ADDR_W'(`IL_FUNC_BASE_OFFSET + 4 * i)) begin
               func_code[i] <= w_data[7:0];
            end
         end
         assign is_drive_rst[i] = (func_code[i] == `IL_FC_DRIVE_RESET);
         assign is_pause_in[i]  = (func_code[i] == `IL_FC_PAUSE_INPUT);
         assign is_pause_rst[i] = (func_code[i] == `IL_FC_PAUSE_RESET);
      end
   endgenerate

   // ---------------- interlock ----------------
   assign drive_req = (|(port_rise & is_drive_rst)) || sw_drive_req;
   assign pause_req = (|(port_rise & is_pause_rst)) || sw_pause_req;
   assign pause_low = |(is_pause_in & ~port_level);

   always_comb begin
      // cause present wins over any request
      next_cutoff = cutoff_latched;
      if (cause_lvl) begin
         next_cutoff = 1'b1;
      end else if (drive_req) begin
         next_cutoff = 1'b0;
      end
      // a pause reset is only honoured once its stop has cleared
      next_pause_estop = pause_estop;
      if (auto_mode && estop_lvl && estop_rec == `IL_REC_CONTINUE) begin
         next_pause_estop = 1'b1;
      end else if (pause_req && !estop_lvl && !cutoff_latched) begin
         next_pause_estop = 1'b0;
      end
      next_pause_dead = pause_dead;
      if (auto_mode && dead_lvl && dead_rec == `IL_REC_CONTINUE) begin
         next_pause_dead = 1'b1;
      end else if (pause_req && !dead_lvl && !cutoff_latched) begin
         next_pause_dead = 1'b0;
      end
      next_pause_input = pause_input;
      if (auto_mode && pause_low) begin
         next_pause_input = 1'b1;
      end else if (!pause_low) begin
         next_pause_input = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cutoff_latched <= 1'b1;
         drive_power_en <= 1'b0;
      end else begin
         cutoff_latched <= next_cutoff;
         drive_power_en <= !next_cutoff;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pause_estop <= 1'b0;
         pause_dead  <= 1'b0;
         pause_input <= 1'b0;
         paused      <= 1'b0;
      end else begin
         pause_estop <= next_pause_estop;
         pause_dead  <= next_pause_dead;
         pause_input <= next_pause_input;
         paused      <= next_pause_estop || next_pause_dead || next_pause_input;
      end
   end

   // ---------------- interrupts ----------------
   always_comb begin
      events = '0;
      events[`IL_EV_CUTOFF]   = next_cutoff && !cutoff_latched;
      events[`IL_EV_RESTORED] = !next_cutoff && cutoff_latched;
      events[`IL_EV_PAUSED]   = (next_pause_estop || next_pause_dead || next_pause_input) &&
                                !paused;
      events[`IL_EV_RESUMED]  = !(next_pause_estop || next_pause_dead || next_pause_input) &&
                                paused;
      // a new event beats the read clear
      next_irq_status = (rd_clear ? '0 : irq_status) | events;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= |(next_irq_status & irq_mask);
      end
   end

   // ---------------- bus read side ----------------
   always_comb begin
      state_word                     = '0;
      state_word[`IL_ST_POWER_BIT]   = drive_power_en;
      state_word[`IL_ST_CUTOFF_BIT]  = cutoff_latched;
      state_word[`IL_ST_P_ESTOP_BIT] = pause_estop;
      state_word[`IL_ST_P_DEAD_BIT]  = pause_dead;
      state_word[`IL_ST_P_INPUT_BIT] = pause_input;
      state_word[`IL_ST_PAUSED_BIT]  = paused;
      state_word[`IL_ST_CAUSE_BIT]   = cause_lvl;
      state_word[`IL_ST_ESTOP_BIT]   = estop_lvl;
      state_word[`IL_ST_DEADMAN_BIT] = dead_lvl;
      rd_mapped = 1'b1;
      rd_word   = '0;
      case (s_axi_araddr)
         `IL_CTRL_OFFSET: begin
            rd_word[`IL_CTRL_ESTOP_REC_LSB +: 4]   = estop_rec;
            rd_word[`IL_CTRL_DEADMAN_REC_LSB +: 4] = dead_rec;
         end
         `IL_STATE_OFFSET:      rd_word = state_word;
         `IL_IRQ_STATUS_OFFSET: rd_word[`IL_EV_WIDTH-1:0] = irq_status;
         `IL_IRQ_MASK_OFFSET:   rd_word[`IL_EV_WIDTH-1:0] = irq_mask;
         default: begin
            rd_mapped = 1'b0;
            for (int k = 0; k < NPORT; k++) begin
               if (s_axi_araddr == ADDR_W'(`IL_FUNC_BASE_OFFSET + 4 * k)) begin
                  rd_mapped    = 1'b1;
                  rd_word[7:0] = func_code[k];
               end
            end
         end
      endcase
   end

   assign rd_fire  = s_axi_arvalid && s_axi_arready;
   assign rd_clear = rd_fire && s_axi_araddr == `IL_IRQ_STATUS_OFFSET;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state      <= interlock_pkg::RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `IL_RESP_OKAY;
      end else begin
         case (rd_state)
            interlock_pkg::RD_IDLE: begin
               if (rd_fire) begin
                  rd_state      <= interlock_pkg::RD_RESP;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rdata   <= rd_word;
                  s_axi_rresp   <= rd_mapped ? `IL_RESP_OKAY : `IL_RESP_DECERR;
               end
            end
            interlock_pkg::RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state      <= interlock_pkg::RD_IDLE;
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid  <= 1'b0;
               end
            end
            default: begin
               rd_state      <= interlock_pkg::RD_IDLE;
               s_axi_arready <= 1'b1;
               s_axi_rvalid  <= 1'b0;
            end
         endcase
      end
   end

   // ---------------- checks ----------------
   a_cutoff_only_code17 : assert property (@(posedge aclk) disable iff (!aresetn)
      cutoff_latched && !sw_drive_req && !(|(port_rise & is_drive_rst)) |=> cutoff_latched)
   else $error("power restored without a code 17 edge");

   a_edge_restores : assert property (@(posedge aclk) disable iff (!aresetn)
      cutoff_latched && !cause_lvl && |(port_rise & is_drive_rst) |=> drive_power_en)
   else $error("recovery edge did not restore drive power");

   a_power_held_off : assert property (@(posedge aclk) disable iff (!aresetn)
      cause_lvl |=> cutoff_latched && !drive_power_en)
   else $error("drive power on while cutoff cause present");

   a_estop_resume : assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(pause_estop) |-> $past(pause_req) && !$past(estop_lvl))
   else $error("estop pause cleared without a valid reset request");

   a_dead_resume : assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(pause_dead) |-> $past(pause_req) && !$past(dead_lvl))
   else $error("deadman pause cleared without a valid reset request");

   a_pause_input : assert property (@(posedge aclk) disable iff (!aresetn)
      auto_mode && pause_low |=> paused ##1 (paused || !pause_low))
   else $error("low pause input did not pause operation");

   a_pause_reset_src : assert property (@(posedge aclk) disable iff (!aresetn)
      pause_estop && !estop_lvl && !cutoff_latched && !(auto_mode && estop_lvl) &&
      |(port_rise & is_pause_rst) |=> !pause_estop)
   else $error("code 7 edge did not clear estop pause");

   a_one_event : assert property (@(posedge aclk) disable iff (!aresetn)
      (port_rise & $past(port_rise)) == '0)
   else $error("input produced two events in a row");

   c_power_restore : cover property (@(posedge aclk) disable iff (!aresetn)
      $fell(cutoff_latched));
   c_estop_resume : cover property (@(posedge aclk) disable iff (!aresetn)
      $fell(pause_estop));
   c_input_resume : cover property (@(posedge aclk) disable iff (!aresetn)
      $fell(pause_input));
endmodule // pause_interlock
`default_nettype wire

// ==== tb/ext_equipment.sv ====
`timescale 1ns/1ps
`default_nettype none
module ext_equipment #(
   parameter int NPORT = 24,
   parameter int HOLD  = 10,
   parameter int GAP   = 40
) (
   input  wire logic             aclk,
   output logic      [NPORT-1:0] port_in,
   output logic                  estop_in,
   output logic                  deadman_stop_in,
   output logic                  cutoff_cause_in
);
   // hold and gap shortened from the real switch timings
   initial begin
      port_in = '0;
      port_in[2] = 1'b1;
      estop_in = 1'b0;
      deadman_stop_in = 1'b0;
      cutoff_cause_in = 1'b0;
   end
   task automatic pulse(input int b);
      @(posedge aclk);
      port_in[b] <= 1'b1;
      repeat (HOLD) @(posedge aclk);
      port_in[b] <= 1'b0;
   endtask
   task automatic set_level(input int b, input logic v);
      @(posedge aclk);
      port_in[b] <= v;
   endtask
   task automatic set_cause(input logic v);
      @(posedge aclk);
      cutoff_cause_in <= v;
   endtask
   task automatic set_stop(input int k, input logic v);
      @(posedge aclk);
      if (k == 0) estop_in <= v;
      else deadman_stop_in <= v;
      if (!v) repeat (GAP) @(posedge aclk);
   endtask
endmodule // ext_equipment
`default_nettype wire

// ==== tb/drive_pause_recovery_interlock_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module drive_pause_recovery_interlock_test;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, auto_mode;
   logic        awready, wready, bvalid, arready, rvalid, irq, pwr, pau, estop, dead, cin;
   logic [7:0]  awaddr, araddr, a;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [23:0] port_in;
   int          mismatches, cmp_count, cyc, pow, cut, cause, rec, inpause, p;
   int          st[2], pend[2];

   pause_interlock i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .port_in(port_in), .estop_in(estop),
      .deadman_stop_in(dead), .cutoff_cause_in(cin), .auto_mode(auto_mode),
      .drive_power_en(pwr), .paused(pau), .irq(irq));
   ext_equipment i_ext (.aclk(aclk), .port_in(port_in), .estop_in(estop),
      .deadman_stop_in(dead), .cutoff_cause_in(cin));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [1:0] er, output logic [31:0] d);
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rready <= 1'b0;
      chk(rresp, er);
   endtask
   // model update plus settle, then outputs against the model
   task automatic look;
      repeat (12) @(posedge aclk);
      chk(pwr, pow[0]);
      chk(pau, pend[0] | pend[1] | inpause);
   endtask
   task automatic s_cause(input int x);
      i_ext.set_cause(x[0]);
      cause = x;
      if (x) cut = 1;
      if (x) pow = 0;
      look();
   endtask
   task automatic s_drive(input int b);
      i_ext.pulse(b);
      if (!cause && cut) pow = 1;
      if (!cause) cut = 0;
      look();
   endtask
   task automatic s_stop(input int k, input int x);
      i_ext.set_stop(k, x[0]);
      st[k] = x;
      if (x && auto_mode && rec == 2) pend[k] = 1;
      look();
   endtask
   task automatic s_preset;
      i_ext.pulse(1);
      for (int k = 0; k < 2; k++) if (!cut && !st[k]) pend[k] = 0;
      look();
   endtask
   task automatic s_pin(input int x);
      i_ext.set_level(2, x[0]);
      if (!x && auto_mode) inpause = 1;
      if (x) inpause = 0;
      look();
   endtask

   initial begin
      void'($urandom(91));
      {aresetn, awvalid, wvalid, bready, arvalid, rready, auto_mode} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      cut = 1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({pwr, pau, irq}, 3'h0);
      rd(8'h0c, 2'h0, v);
      chk(v, 32'h0);
      wr(8'h40, 32'h11, 2'h0);
      wr(8'h44, 32'h07, 2'h0);
      wr(8'h48, 32'h08, 2'h0);
      wr(8'h80, 32'h11, 2'h0);
      wr(8'h00, 32'h22, 2'h0);
      rec = 2;
      rd(8'h40, 2'h0, v);
      chk(v, 32'h11);
      wr(8'ha0, 32'h11, 2'h3);
      rd(8'ha0, 2'h3, v);
      chk(v, 32'h0);
      rd(8'h08, 2'h0, v);
      $display("test config done");
      s_drive(0);
      chk(irq, 1'b0);
      wr(8'h0c, 32'hf, 2'h0);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1);
      rd(8'h08, 2'h0, v);
      chk(v, 32'h2);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(8'h0c, 32'h0, 2'h0);
      $display("test irq done");
      s_cause(1);
      s_drive(0);
      s_cause(0);
      s_preset();
      s_drive(16);
      for (int i = 0; i < 3; i++) begin
         p = 3 + $urandom % 21;
         a = 8'h40 + 8'(4 * p);
         wr(a, 32'h11, 2'h0);
         s_cause(1);
         s_cause(0);
         s_drive(p);
      end
      s_cause(1);
      s_cause(0);
      wr(8'h00, 32'h122, 2'h0);
      pow = 1;
      cut = 0;
      look();
      rd(8'h00, 2'h0, v);
      chk(v, 32'h22);
      $display("test drive recovery done");
      auto_mode <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         s_stop(k, 1);
         s_preset();
         s_stop(k, 0);
         s_preset();
      end
      s_pin(0);
      s_pin(1);
      $display("test pause done");
      s_stop(0, 1);
      s_cause(1);
      s_stop(0, 0);
      s_cause(0);
      s_preset();
      s_drive(0);
      s_preset();
      wr(8'h00, 32'h0, 2'h0);
      rec = 0;
      s_stop(0, 1);
      s_stop(0, 0);
      $display("test combined done");
      print_verdict();
   end
endmodule // drive_pause_recovery_interlock_test
`default_nettype wire
